/* swg_regs.svh */
// Timing constants and field values for the supervisor watchdog and memory guard.
// Assumes a 100 MHz core clock; times are given in their own unit, counts derived.
`ifndef SWG_REGS_SVH
`define SWG_REGS_SVH

`define SWG_CLK_PERIOD_NS 10
`define SWG_TICK_US 1000
`define SWG_TICK_CYCLES ((`SWG_TICK_US * 1000) / `SWG_CLK_PERIOD_NS)
`define SWG_TIMEOUT_MS 1000
`define SWG_TIMEOUT_TICKS ((`SWG_TIMEOUT_MS * 1000 + `SWG_TICK_US - 1) / `SWG_TICK_US)
`define SWG_RESET_MS 140
`define SWG_RESET_TICKS ((`SWG_RESET_MS * 1000 + `SWG_TICK_US - 1) / `SWG_TICK_US)
`define SWG_TICK_W 17
`define SWG_CNT_W 11

`endif

/* swg_pkg.sv */
// Types shared by the supervisor watchdog and memory guard.
// Assumes nothing beyond the timing header.
package swg_pkg;
	typedef enum logic [2:0] {
		SWG_OFF = 3'h1,
		SWG_RUN = 3'h2,
		SWG_RST = 3'h4
	} swg_state_e;
endpackage

/* swg_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous input; the first stage feeds only the second.
`timescale 1ns/1ps
module swg_sync #(
	parameter bit RESET_VAL = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic async_in,
	output logic sync_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Change counts once stages two and three agree
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_out <= RESET_VAL;
		end else if (s2_q == s3_q) begin
			sync_out <= s3_q;
		end
	end
endmodule

/* swg_top.sv */
// Supervisor watchdog, power-fail warning and battery RAM chip-select gate.
// Assumes analog front ends deliver single-bit indications, all asynchronous.
// Operation
// R1: With supply valid, gated select follows select input uninverted.
// R2: Supply invalid or below backup cell forces gated select high.
// R3: Warning output low while power-fail sense is below reference.
// R4: Warning follows comparator directly, no internal hysteresis.
// R5: Missed kick asserts reset outputs for at least the reset time.
// R6: Timeout is fixed, with a guaranteed minimum.
// R7: Timeout count restarts when reset outputs go inactive.
// R8: Any kick edge before timeout restarts the timeout count.
// R9: Constant kick gives periodic reset pulses, timeout plus reset time.
// R10: Floating kick disables watchdog; no resets, status unchanged.
// R11: Watchdog disabled while supply is invalid.
// R12: Timeout drives status low until the next kick edge.
// R13: Status forced high while supply is invalid.
// R14: Processor must kick within the minimum timeout period.
// R15: On backup cell, inputs ignored; warning low, status and select high.
// R16: Analog indications as bits; durations from a prescaled tick count.
`timescale 1ns/1ps
`include "swg_regs.svh"
module swg_top #(
	parameter int TICK_CYCLES = `SWG_TICK_CYCLES,
	parameter int TIMEOUT_TICKS = `SWG_TIMEOUT_TICKS,
	parameter int RESET_TICKS = `SWG_RESET_TICKS
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic main_supply_ok,
	input wire logic backup_active,
	input wire logic power_fail_sense,
	input wire logic watchdog_kick,
	input wire logic kick_floating,
	input wire logic ram_sel_n,
	output logic ram_sel_gated_n,
	output logic power_fail_warn_n,
	output logic watchdog_expired_n,
	output logic wd_reset_n,
	output logic wd_reset
);
	logic supply_s;
	logic backup_s;
	logic below_s;
	logic kick_s;
	logic float_s;
	logic sel_s;
	logic kick_prev_q;
	logic kick_edge;
	logic supply_good;
	logic [`SWG_TICK_W-1:0] pre_q;
	logic tick;
	logic restart;
	logic [`SWG_CNT_W-1:0] cnt_q;
	swg_pkg::swg_state_e state_q;

	swg_sync #(.RESET_VAL(1'b0)) u_sup (.core_clk(core_clk), .rst_b(rst_b),
		.async_in(main_supply_ok), .sync_out(supply_s));
	swg_sync #(.RESET_VAL(1'b1)) u_bak (.core_clk(core_clk), .rst_b(rst_b),
		.async_in(backup_active), .sync_out(backup_s));
	swg_sync #(.RESET_VAL(1'b0)) u_pfs (.core_clk(core_clk), .rst_b(rst_b),
		.async_in(power_fail_sense), .sync_out(below_s));
	swg_sync #(.RESET_VAL(1'b0)) u_kck (.core_clk(core_clk), .rst_b(rst_b),
		.async_in(watchdog_kick), .sync_out(kick_s));
	swg_sync #(.RESET_VAL(1'b1)) u_flt (.core_clk(core_clk), .rst_b(rst_b),
		.async_in(kick_floating), .sync_out(float_s));
	swg_sync #(.RESET_VAL(1'b1)) u_sel (.core_clk(core_clk), .rst_b(rst_b),
		.async_in(ram_sel_n), .sync_out(sel_s));

	// R11: supply gate
	assign supply_good = supply_s && !backup_s;
	// R8: either polarity
	assign kick_edge = (kick_s != kick_prev_q) && supply_good && !float_s;
	assign tick = (pre_q == `SWG_TICK_W'(TICK_CYCLES - 1));
	// R6: kick aligns time base, so a full timeout always elapses after it
	assign restart = (state_q == swg_pkg::SWG_OFF)
		|| (state_q == swg_pkg::SWG_RUN && kick_edge);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			kick_prev_q <= 1'b0;
		end else begin
			kick_prev_q <= kick_s;
		end
	end

	// R16: prescaled time base
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_q <= '0;
		end else if (tick || restart) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + `SWG_TICK_W'(1);
		end
	end

	// R1: select passes through
	// R2: blocked when supply bad
	// R15: held high on backup
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ram_sel_gated_n <= 1'b1;
		end else begin
			ram_sel_gated_n <= supply_good ? sel_s : 1'b1;
		end
	end

	// R3: warning follows comparator
	// R4: no hysteresis
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			power_fail_warn_n <= 1'b0;
		end else if (backup_s) begin
			power_fail_warn_n <= 1'b0;
		end else begin
			power_fail_warn_n <= !below_s;
		end
	end

	// R5: timeout then reset
	// R6: fixed period
	// R7: restart after reset
	// R9: periodic while idle
	// R10: floating disables
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= swg_pkg::SWG_OFF;
			cnt_q <= '0;
		end else begin
			unique case (state_q)
				swg_pkg::SWG_OFF: begin
					cnt_q <= '0;
					if (supply_good && !float_s) begin
						state_q <= swg_pkg::SWG_RUN;
					end
				end
				swg_pkg::SWG_RUN: begin
					if (!supply_good || float_s) begin
						state_q <= swg_pkg::SWG_OFF;
						cnt_q <= '0;
					end else if (kick_edge) begin
						cnt_q <= '0;
					end else if (tick) begin
						if (cnt_q == `SWG_CNT_W'(TIMEOUT_TICKS - 1)) begin
							state_q <= swg_pkg::SWG_RST;
							cnt_q <= '0;
						end else begin
							cnt_q <= cnt_q + `SWG_CNT_W'(1);
						end
					end
				end
				swg_pkg::SWG_RST: begin
					if (!supply_good) begin
						state_q <= swg_pkg::SWG_OFF;
						cnt_q <= '0;
					end else if (tick) begin
						if (cnt_q == `SWG_CNT_W'(RESET_TICKS)) begin
							state_q <= swg_pkg::SWG_RUN;
							cnt_q <= '0;
						end else begin
							cnt_q <= cnt_q + `SWG_CNT_W'(1);
						end
					end
				end
				default: begin
					state_q <= swg_pkg::SWG_OFF;
					cnt_q <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_reset_n <= 1'b1;
			wd_reset <= 1'b0;
		end else begin
			wd_reset_n <= (state_q != swg_pkg::SWG_RST);
			wd_reset <= (state_q == swg_pkg::SWG_RST);
		end
	end

	// R12: low on timeout until kick
	// R13: forced high on bad supply
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			watchdog_expired_n <= 1'b1;
		end else if (!supply_good) begin
			watchdog_expired_n <= 1'b1;
		end else if (state_q == swg_pkg::SWG_RUN && tick && !kick_edge && !float_s
				&& cnt_q == `SWG_CNT_W'(TIMEOUT_TICKS - 1)) begin
			watchdog_expired_n <= 1'b0;
		end else if (kick_edge) begin
			watchdog_expired_n <= 1'b1;
		end
	end

	sequence s_timeout_hit;
		state_q == swg_pkg::SWG_RUN && tick && supply_good && !float_s && !kick_edge
			&& cnt_q == `SWG_CNT_W'(TIMEOUT_TICKS - 1);
	endsequence

	sequence s_pulse_start;
		state_q == swg_pkg::SWG_RST && !watchdog_expired_n ##1 !wd_reset_n && wd_reset;
	endsequence

	property p_timeout;
		@(posedge core_clk) disable iff (!rst_b)
		s_timeout_hit |=> s_pulse_start;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not start pulse"); // R12

	property p_gate_pass;
		@(posedge core_clk) disable iff (!rst_b)
		supply_good |=> ram_sel_gated_n == $past(sel_s);
	endproperty
	a_gate_pass: assert property (p_gate_pass) else $error("gated select mismatch"); // R1

	property p_gate_block;
		@(posedge core_clk) disable iff (!rst_b)
		!supply_good |=> ram_sel_gated_n;
	endproperty
	a_gate_block: assert property (p_gate_block) else $error("select not blocked"); // R2

	property p_warn;
		@(posedge core_clk) disable iff (!rst_b)
		!backup_s |=> power_fail_warn_n == !$past(below_s);
	endproperty
	a_warn: assert property (p_warn) else $error("warning wrong"); // R3

	property p_rst_out;
		@(posedge core_clk) disable iff (!rst_b)
		state_q == swg_pkg::SWG_RST |=> !wd_reset_n && wd_reset;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("reset outputs wrong"); // R5

	property p_kick_clear;
		@(posedge core_clk) disable iff (!rst_b)
		state_q == swg_pkg::SWG_RUN && kick_edge && supply_good |=> cnt_q == '0;
	endproperty
	a_kick_clear: assert property (p_kick_clear) else $error("kick did not clear"); // R8

	property p_restart;
		@(posedge core_clk) disable iff (!rst_b)
		$fell(state_q == swg_pkg::SWG_RST) |-> cnt_q == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("count not restarted"); // R7

	property p_float;
		@(posedge core_clk) disable iff (!rst_b)
		float_s && state_q != swg_pkg::SWG_RST |=> state_q == swg_pkg::SWG_OFF;
	endproperty
	a_float: assert property (p_float) else $error("floating kick not idle"); // R10

	property p_status_high;
		@(posedge core_clk) disable iff (!rst_b)
		!supply_good |=> watchdog_expired_n;
	endproperty
	a_status_high: assert property (p_status_high) else $error("status not high"); // R13

	property p_backup;
		@(posedge core_clk) disable iff (!rst_b)
		backup_s |=> !power_fail_warn_n && ram_sel_gated_n && watchdog_expired_n;
	endproperty
	a_backup: assert property (p_backup) else $error("backup outputs wrong"); // R15
endmodule

/* swg_cpu_model.sv */
// Processor model: toggles the watchdog kick at a chosen spacing.
// Assumes it shares the block's core clock and drives on falling edges.
`timescale 1ns/1ps
module swg_cpu_model (
	input wire logic core_clk,
	input wire logic kick_en,
	input wire logic [15:0] kick_gap,
	output logic watchdog_kick
);
	int cnt = 0;
	initial watchdog_kick = 1'b0;
	always @(negedge core_clk) begin
		cnt = cnt + 1;
		if (kick_en && cnt >= int'(kick_gap)) begin
			watchdog_kick = ~watchdog_kick;
			cnt = 0;
		end
	end
endmodule

/* swg_top_bench.sv */
// Self-checking bench for the watchdog, warning output and select gate.
// Assumes shortened tick counts; outputs sampled at falling edges.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
	$display("mismatch at %0t: got %b want %b", $time, a, b); end end
module swg_top_bench;
	localparam int TK = 4, TO = 10, RT = 3;
	logic core_clk = 0, rst_b = 0, supply_ok = 1, backup = 0, pf_sense = 0;
	logic floating = 0, sel_n = 1, kick_en = 0, prev_rst = 0;
	logic [15:0] gap = 16'h14;
	logic kick, sel_g_n, warn_n, exp_n, rst_n_o, rst_o;
	int num_errors = 0, samples_checked = 0, cyc = 0, rises = 0, rise_at = 0;
	int width = 0, gap_seen = 0, fall_at = 0, r0 = 0;
	int stab = 0, since_kick = 0, kick_at = 0;
	logic kick_d = 0;
	logic [3:0] in_q = 4'h0;
	always #5 core_clk = ~core_clk;
	swg_cpu_model swg_cpu_model_i (.core_clk(core_clk), .kick_en(kick_en), .kick_gap(gap),
		.watchdog_kick(kick));
	swg_top #(.TICK_CYCLES(TK), .TIMEOUT_TICKS(TO), .RESET_TICKS(RT)) swg_top_i (
		.core_clk(core_clk), .rst_b(rst_b), .main_supply_ok(supply_ok),
		.backup_active(backup), .power_fail_sense(pf_sense), .watchdog_kick(kick),
		.kick_floating(floating), .ram_sel_n(sel_n), .ram_sel_gated_n(sel_g_n),
		.power_fail_warn_n(warn_n), .watchdog_expired_n(exp_n), .wd_reset_n(rst_n_o),
		.wd_reset(rst_o));
	// Pulse timing monitor in cycles
	always @(negedge core_clk) begin
		cyc++;
		if (kick !== kick_d) kick_at = cyc;
		kick_d = kick;
		if (rst_o === 1'b1 && prev_rst === 1'b0) begin
			rises++;
			since_kick = cyc - kick_at;
			gap_seen = cyc - fall_at;
			rise_at = cyc;
		end
		if (rst_o === 1'b0 && prev_rst === 1'b1) begin
			width = cyc - rise_at;
			fall_at = cyc;
		end
		prev_rst = rst_o;
		if (rst_b) `CHK(rst_n_o, ~rst_o)
		// Reference model of gate and warning once the inputs have settled
		if (!rst_b || {supply_ok, backup, sel_n, pf_sense} !== in_q) stab = 0;
		else stab++;
		in_q = {supply_ok, backup, sel_n, pf_sense};
		if (stab >= 6) begin
			`CHK(sel_g_n, (supply_ok && !backup) ? sel_n : 1'b1)
			`CHK(warn_n, backup ? 1'b0 : ~pf_sense)
		end
	end
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wait_rises(input int n);
		for (int i = 0; i < 400 && rises < n; i++) @(negedge core_clk);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	initial begin
		void'($urandom(32'hab609736));
		idle(12);
		rst_b = 1;
		kick_en = 1;
		for (int i = 0; i < 20; i++) begin
			sel_n = 1'($urandom);
			pf_sense = 1'($urandom);
			idle(8);
			`CHK(sel_g_n, sel_n)
			`CHK(warn_n, ~pf_sense)
		end
		`CHK(rises, 0)
		kick_en = 0;
		wait_rises(1);
		`CHK(since_kick >= TO * TK, 1'b1)
		wait_rises(2);
		idle(2);
		`CHK(exp_n, 1'b0)
		`CHK(gap_seen >= TO * TK && gap_seen <= (TO + 1) * TK + 4, 1'b1)
		idle(30);
		`CHK(width >= RT * TK && width <= (RT + 2) * TK, 1'b1)
		`CHK(exp_n, 1'b0)
		kick_en = 1;
		idle(2);
		kick_en = 0;
		r0 = rises;
		idle(8);
		`CHK(exp_n, 1'b1)
		floating = 1;
		idle(300);
		`CHK(rises, r0)
		`CHK(exp_n, 1'b1)
		floating = 0;
		wait_rises(r0 + 1);
		supply_ok = 0;
		sel_n = 0;
		idle(8);
		`CHK(exp_n, 1'b1)
		`CHK(sel_g_n, 1'b1)
		idle(30);
		r0 = rises;
		idle(200);
		`CHK(rises, r0)
		supply_ok = 1;
		backup = 1;
		pf_sense = 0;
		idle(8);
		`CHK(warn_n, 1'b0)
		`CHK(sel_g_n, 1'b1)
		`CHK(exp_n, 1'b1)
		tally_and_finish();
	end
	initial begin
		idle(3000);
		num_errors++;
		tally_and_finish();
	end
endmodule
